// ### common/regfront_pkg.sv
// Summary of operation
// - read-clear bits clear on host read
// - self-clearing bits return to zero themselves
// - latched low/high bits hold until read
// - strap bits load from straps at startup
// - decode shared, output-port, reserved regions
// - paged port reads, enabled-port broadcast writes
// - 0xd0-0xdf per-port test registers
// - blocks reachable from i2c and link
// - address field reads current target address
// - no override: field ignores writes, shows strap
// - override set: field writable, address used
// - address default 0x3d, override default zero
// - bit 2 restarts autoload, self-clears
// - bit 1 full reset incl registers, self-clears
// - bit 0 logic reset keeping registers
// - init-done bit 0x04[6] set after init
package regfront_pkg;
    // =========================================
    // register offsets
    localparam logic [7:0] addr_target = 8'h00;
    localparam logic [7:0] addr_reset = 8'h01;
    localparam logic [7:0] addr_status = 8'h04;
    localparam logic [7:0] addr_port_sel = 8'h4c;
    localparam logic [7:0] shared_last = 8'h31;
    localparam logic [7:0] outport_first = 8'h32;
    localparam logic [7:0] outport_last = 8'h3a;
    localparam logic [7:0] rsvd_first = 8'h3b;
    localparam logic [7:0] rsvd_last = 8'h4b;
    localparam logic [7:0] paged_first = 8'h4c;
    localparam logic [7:0] paged_last = 8'h7f;
    localparam logic [7:0] test_first = 8'hd0;
    localparam logic [7:0] test_last = 8'hdf;
    // =========================================
    // field positions and reset values
    localparam int bit_override = 0;
    localparam int bit_logic_reset = 0;
    localparam int bit_full_reset = 1;
    localparam int bit_reload = 2;
    localparam int bit_init_done = 6;
    localparam int bit_rd_port_lo = 4;
    localparam logic [6:0] target_default = 7'h3d;
    localparam logic [7:0] reset_default = 8'h00;
    localparam logic [7:0] port_sel_default = 8'h00;
    // =========================================
    // action durations
    localparam int reset_pulse_ns = 64;
    localparam int reload_ns = 800;
    localparam int mclk_ns = 8;
    localparam int reset_cycles = (reset_pulse_ns + mclk_ns - 1) / mclk_ns;
    localparam int reload_cycles = (reload_ns + mclk_ns - 1) / mclk_ns;
    localparam int num_ports = 2;

    typedef enum logic [5:0] {
        reg_none = 6'b000001,
        reg_shared = 6'b000010,
        reg_outport = 6'b000100,
        reg_reserved = 6'b001000,
        reg_paged = 6'b010000,
        reg_test = 6'b100000
    } region_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } access_t;
endpackage

// ### dv/link_host.sv
`timescale 1ns/10ps
// ========================================
// host reaching the registers over the link
module link_host (
    input wire logic mclk,
    output regfront_pkg::access_t req
);
    initial req = '0;
    // one-cycle strobe, same timing as the local host
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1 req = '{1'b1, 1'b0, a, d};
        @(posedge mclk);
        #1 req = '0;
    endtask
endmodule

// ### dv/reg_front_chk.sv
`timescale 1ns/10ps
// ========================================
// port checker
module reg_front_chk (
    input wire logic mclk,
    input wire logic nrst,
    input wire regfront_pkg::access_t i2c_req,
    input wire regfront_pkg::access_t link_req,
    input wire regfront_pkg::region_t region,
    input wire logic [1:0] paged_wr_ports,
    input wire logic [1:0] test_wr_ports,
    input wire logic logic_reset,
    input wire logic full_reset,
    input wire logic reload_active,
    input wire logic init_done
);
    regfront_pkg::access_t a;
    // local host wins a collision
    assign a = (i2c_req.wr | i2c_req.rd) ? i2c_req : link_req;
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    a_init_mirror: assert property (
        a.wr && a.addr == 8'h01 && a.wdata[2] |=> !init_done)
        else $error("init flag wrong");
    a_full_implies: assert property (
        a.wr && a.addr == 8'h01 && a.wdata[1] |=> full_reset && logic_reset)
        else $error("full reset not started");
    a_full_ends: assert property (
        $rose(full_reset) |-> ##[1:9] !full_reset)
        else $error("full reset stuck");
    a_reset_cause: assert property (
        $rose(logic_reset) |-> $past(a.wr) && $past(a.addr) == 8'h01)
        else $error("stray reset");
    a_reload_len: assert property (
        $rose(reload_active) |-> ##[95:105] !reload_active)
        else $error("reload length");
    a_reserved_map: assert property (
        a.rd && a.addr inside {[8'h3b:8'h4b]}
        |-> region == regfront_pkg::reg_reserved) else $error("reserved");
    a_outport_map: assert property (
        a.rd && a.addr inside {[8'h32:8'h3a]}
        |-> region == regfront_pkg::reg_outport) else $error("outport");
    a_test_idle: assert property (
        !(a.wr && a.addr inside {[8'hd0:8'hdf]})
        |-> test_wr_ports == 2'b00) else $error("test write stray");
    a_paged_idle: assert property (
        !(a.wr && a.addr inside {[8'h4d:8'h7f]})
        |-> paged_wr_ports == 2'b00) else $error("paged write stray");
    c_full: cover property ($rose(full_reset));
    c_reload: cover property ($fell(reload_active));
    c_bcast: cover property (paged_wr_ports == 2'b11);
endmodule
bind reg_front reg_front_chk i_chk (.mclk(mclk), .nrst(nrst),
    .i2c_req(i2c_req), .link_req(link_req), .region(region),
    .paged_wr_ports(paged_wr_ports), .test_wr_ports(test_wr_ports),
    .logic_reset(logic_reset), .full_reset(full_reset),
    .reload_active(reload_active), .init_done(init_done));

// ### dv/tb.sv
`timescale 1ns/10ps
// ========================================
// bench
module tb;
    logic mclk = 0;
    logic nrst = 0;
    regfront_pkg::access_t i2c_req = '0;
    regfront_pkg::access_t link_req;
    logic [7:0] rdata, d;
    logic [7:0] ext_rdata = 8'ha5;
    logic [6:0] strap_address = 7'h2a;
    logic [6:0] active_address;
    regfront_pkg::region_t region, s_reg;
    logic [1:0] paged_wr_ports, paged_rd_port, test_wr_ports, s_pw, s_tw;
    logic logic_reset, full_reset, reload_active, init_done;
    int num_errors = 0;
    int compares = 0;
    always #4 mclk = ~mclk;
    reg_front i_dut (.mclk(mclk), .nrst(nrst), .i2c_req(i2c_req),
        .link_req(link_req), .rdata(rdata), .strap_address(strap_address),
        .active_address(active_address), .region(region),
        .paged_wr_ports(paged_wr_ports), .paged_rd_port(paged_rd_port),
        .test_wr_ports(test_wr_ports), .ext_rdata(ext_rdata),
        .logic_reset(logic_reset), .full_reset(full_reset),
        .reload_active(reload_active), .init_done(init_done));
    link_host i_host (.mclk(mclk), .req(link_req));
    task conclude;
        if (num_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t %h %h", $time, seen, exp);
        end
    endtask
    // decode outputs are pulses, so grab them inside the access cycle
    task go(input logic w, input logic [7:0] a, input logic [7:0] wd);
        @(posedge mclk);
        #1 i2c_req = '{w, !w, a, wd};
        #1 s_reg = region;
        s_pw = paged_wr_ports;
        s_tw = test_wr_ports;
        @(posedge mclk);
        #1 i2c_req = '0;
        d = rdata;
    endtask
    // polling stays bounded so a stuck busy flag cannot hang the run
    task settle;
        int n;
        for (n = 0; n < 300 && (logic_reset || !init_done); n++) begin
            @(posedge mclk);
            #1;
        end
        if (logic_reset || !init_done) begin
            num_errors++;
            conclude();
        end
    endtask
    task t_addr;
        settle();
        go(1'b0, 8'h00, 8'h00);
        chk(d, 8'h54);
        go(1'b1, 8'h00, 8'h2a);
        go(1'b0, 8'h00, 8'h00);
        chk(d, 8'h54);
        // the field only opens once the override is already set
        i_host.put(8'h00, 8'h2b);
        go(1'b0, 8'h00, 8'h00);
        chk(d, 8'h55);
        i_host.put(8'h00, 8'h2b);
        go(1'b0, 8'h00, 8'h00);
        chk(d, 8'h2b);
        chk({1'b0, active_address}, 8'h15);
    endtask
    task t_resets;
        go(1'b1, 8'h01, 8'h01);
        chk({6'h0, full_reset, logic_reset}, 8'h01);
        go(1'b0, 8'h01, 8'h00);
        chk(d, 8'h01);
        settle();
        go(1'b0, 8'h00, 8'h00);
        chk(d, 8'h2b);
        go(1'b1, 8'h01, 8'h02);
        chk({6'h0, full_reset, logic_reset}, 8'h03);
        settle();
        go(1'b0, 8'h00, 8'h00);
        chk(d, 8'h54);
        go(1'b1, 8'h01, 8'h04);
        chk({6'h0, reload_active, init_done}, 8'h02);
        settle();
        go(1'b0, 8'h04, 8'h00);
        chk({7'h0, d[6]}, 8'h01);
        go(1'b0, 8'h01, 8'h00);
        chk(d, 8'h00);
    endtask
    task t_map;
        go(1'b1, 8'h4c, 8'h13);
        chk({6'h0, paged_rd_port}, 8'h01);
        go(1'b1, 8'h50, 8'h00);
        chk({6'h0, s_pw}, 8'h03);
        go(1'b0, 8'h50, 8'h00);
        chk(d, 8'ha5);
        go(1'b1, 8'h4c, 8'h01);
        go(1'b0, 8'h4c, 8'h00);
        chk(d, 8'h01);
        go(1'b1, 8'h50, 8'h00);
        chk({6'h0, s_pw}, 8'h01);
        go(1'b0, 8'h3b, 8'h00);
        chk(d, 8'h00);
        go(1'b0, 8'h35, 8'h00);
        chk({2'h0, s_reg}, 8'h04);
        go(1'b1, 8'hd5, 8'h00);
        chk({2'h0, s_reg}, 8'h20);
        chk({6'h0, s_tw}, 8'h01);
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        chk({1'b0, active_address}, 8'h3d);
        #1 nrst = 1;
        t_addr();
        t_resets();
        t_map();
        conclude();
    end
endmodule

// ### hdl/reg_front.sv
`timescale 1ns/10ps
module reg_front (
    input wire logic mclk,
    input wire logic nrst,
    input wire regfront_pkg::access_t i2c_req,
    input wire regfront_pkg::access_t link_req,
    output logic [7:0] rdata,
    input wire logic [6:0] strap_address,
    output logic [6:0] active_address,
    output regfront_pkg::region_t region,
    output logic [1:0] paged_wr_ports,
    output logic [1:0] paged_rd_port,
    output logic [1:0] test_wr_ports,
    input wire logic [7:0] ext_rdata,
    output logic logic_reset,
    output logic full_reset,
    output logic reload_active,
    output logic init_done
);
    // =========================================
    // access merge: local i2c wins a same-cycle clash
    regfront_pkg::access_t acc;
    regfront_pkg::access_t next_acc;
    always_comb begin
        next_acc = (i2c_req.wr | i2c_req.rd) ? i2c_req : link_req;
    end
    assign acc = next_acc;

    function automatic regfront_pkg::region_t decode(input logic [7:0] a);
        if (a <= regfront_pkg::shared_last) begin
            decode = regfront_pkg::reg_shared;
        end else if (a >= regfront_pkg::outport_first &&
                     a <= regfront_pkg::outport_last) begin
            decode = regfront_pkg::reg_outport;
        end else if (a >= regfront_pkg::rsvd_first &&
                     a <= regfront_pkg::rsvd_last) begin
            decode = regfront_pkg::reg_reserved;
        end else if (a >= regfront_pkg::paged_first &&
                     a <= regfront_pkg::paged_last) begin
            decode = regfront_pkg::reg_paged;
        end else if (a >= regfront_pkg::test_first &&
                     a <= regfront_pkg::test_last) begin
            decode = regfront_pkg::reg_test;
        end else begin
            decode = regfront_pkg::reg_none;
        end
    endfunction

    regfront_pkg::region_t cur_region;
    assign cur_region = decode(acc.addr);
    assign region = cur_region;

    // =========================================
    // registers
    logic [6:0] target_field;
    logic override;
    logic [7:0] port_sel;
    logic [7:0] reset_bits;
    logic [7:0] reset_cnt;
    logic [7:0] reload_cnt;
    logic soft_clear;
    logic wr_target;
    logic wr_reset;
    logic wr_sel;

    assign wr_target = acc.wr && acc.addr == regfront_pkg::addr_target;
    assign wr_reset = acc.wr && acc.addr == regfront_pkg::addr_reset;
    assign wr_sel = acc.wr && acc.addr == regfront_pkg::addr_port_sel;
    // full reset clears override and port select and reloads the strap address; logic reset does not
    assign soft_clear = full_reset;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            override <= 1'b0;
            target_field <= regfront_pkg::target_default;
        end else if (soft_clear || reload_active) begin
            override <= 1'b0;
            target_field <= strap_address;
        end else if (wr_target) begin
            override <= acc.wdata[regfront_pkg::bit_override];
            if (override) begin
                target_field <= acc.wdata[7:1];
            end
        end else if (!override) begin
            target_field <= strap_address;
        end
    end
    // override set: field holds what host wrote
    assign active_address = target_field;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            port_sel <= regfront_pkg::port_sel_default;
        end else if (soft_clear) begin
            port_sel <= regfront_pkg::port_sel_default;
        end else if (wr_sel) begin
            port_sel <= acc.wdata;
        end
    end

    // paged reads pick one port; writes fan out to every enabled one
    assign paged_rd_port = port_sel[regfront_pkg::bit_rd_port_lo +: 2];
    assign paged_wr_ports = (acc.wr && cur_region == regfront_pkg::reg_paged
                             && !wr_sel) ? port_sel[1:0] : 2'b00;
    assign test_wr_ports = (acc.wr && cur_region == regfront_pkg::reg_test)
                           ? port_sel[1:0] : 2'b00;

    // =========================================
    // self-clearing reset and reload bits
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reset_bits <= regfront_pkg::reset_default;
        end else if (wr_reset) begin
            reset_bits <= acc.wdata;
        end else begin
            if (reset_cnt == 8'h01) begin
                reset_bits[regfront_pkg::bit_full_reset] <= 1'b0;
                reset_bits[regfront_pkg::bit_logic_reset] <= 1'b0;
            end
            if (reload_cnt == 8'h01) begin
                reset_bits[regfront_pkg::bit_reload] <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reset_cnt <= 8'h00;
        end else if (wr_reset && (acc.wdata[1] | acc.wdata[0])) begin
            reset_cnt <= 8'(regfront_pkg::reset_cycles);
        end else if (reset_cnt != 8'h00) begin
            reset_cnt <= reset_cnt - 8'h01;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reload_cnt <= 8'(regfront_pkg::reload_cycles);
        end else if (wr_reset && acc.wdata[regfront_pkg::bit_reload]) begin
            reload_cnt <= 8'(regfront_pkg::reload_cycles);
        end else if (reload_cnt != 8'h00) begin
            reload_cnt <= reload_cnt - 8'h01;
        end
    end

    // reserved bits 7:3 are kept as written
    assign full_reset = reset_bits[regfront_pkg::bit_full_reset];
    assign logic_reset = reset_bits[regfront_pkg::bit_logic_reset] |
                         full_reset;
    assign reload_active = reload_cnt != 8'h00;
    assign init_done = !reload_active;

    // =========================================
    // read data, registered
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (acc.rd) begin
            unique case (acc.addr)
                regfront_pkg::addr_target:
                    rdata <= {target_field, override};
                regfront_pkg::addr_reset: rdata <= reset_bits;
                regfront_pkg::addr_status:
                    rdata <= {1'b0, init_done, 6'h00};
                regfront_pkg::addr_port_sel: rdata <= port_sel;
                default:
                    rdata <= (cur_region == regfront_pkg::reg_reserved ||
                              cur_region == regfront_pkg::reg_none)
                             ? 8'h00 : ext_rdata;
            endcase
        end
    end
    // no read-clear or latched bits live here; those belong to the
    // port blocks behind ext_rdata, which clear on their own read
endmodule
